// File: verilog/rtf_chains.sv
`timescale 1ns/1ps
module rtf_fir
	import rtf_pkg::*;
#(
	parameter int NT = 3 // Tap count.
) (
	input  wire logic            aclk,    // Clock.
	input  wire logic            aresetn, // Reset, low.
	input  wire logic            run,     // Output-rate strobe.
	input  wire logic            take,    // Input-rate strobe.
	input  wire logic            en,      // Filter on.
	input  wire logic [NT*16-1:0] coef,   // Taps, tap 0 low.
	input  wire logic [4:0]      sh,      // Scale shift.
	input  rtf_iq_s              x,       // Input sample.
	output rtf_iq_s              y        // Output sample.
);
	rtf_iq_s            hist [NT];
	logic signed [39:0] acc_i;
	logic signed [39:0] acc_q;

	always_comb begin
		acc_i = '0;
		acc_q = '0;
		for (int k = 0; k < NT; k++) begin
			acc_i = acc_i + 40'($signed(coef[k*16 +: 16]) * hist[k].i);
			acc_q = acc_q + 40'($signed(coef[k*16 +: 16]) * hist[k].q);
		end
	end

	// Zero stuffing: between input strobes the history takes zeros.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int k = 0; k < NT; k++)
				hist[k] <= '0;
		end else if (run) begin
			hist[0] <= take ? x : '0;
			for (int k = 1; k < NT; k++)
				hist[k] <= hist[k-1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			y <= '0;
		else if (run)
			y <= en ? {rtf_scale(acc_i, sh), rtf_scale(acc_q, sh)} : x;
	end
endmodule

module rtf_chains
	import rtf_pkg::*;
#(
	parameter int NUM_TX = 8,  // Transmit chains.
	parameter int AW     = 8,  // Bus address width.
	parameter int CAP_N  = 64, // Capture depth.
	parameter int PT     = 24  // Compensation taps.
) (
	input  wire logic            aclk,         // Clock.
	input  wire logic            aresetn,      // Reset, low.
	input  wire logic [AW-1:0]   awaddr,       // Write address.
	input  wire logic            awvalid,      // Address valid.
	output logic                 awready,      // Address ready.
	input  wire logic [31:0]     wdata,        // Write data.
	input  wire logic [3:0]      wstrb,        // Byte enables.
	input  wire logic            wvalid,       // Data valid.
	output logic                 wready,       // Data ready.
	output logic [1:0]           bresp,        // Write response.
	output logic                 bvalid,       // Response valid.
	input  wire logic            bready,       // Response ready.
	input  wire logic [AW-1:0]   araddr,       // Read address.
	input  wire logic            arvalid,      // Address valid.
	output logic                 arready,      // Address ready.
	output logic [31:0]          rdata,        // Read data.
	output logic [1:0]           rresp,        // Read response.
	output logic                 rvalid,       // Read valid.
	input  wire logic            rready,       // Read ready.
	input  rtf_iq_s              rx_in,        // Converter sample.
	input  wire logic            rx_in_valid,  // Sample strobe.
	output rtf_iq_s              rx_out,       // Framer sample.
	output logic                 rx_out_valid, // Framer strobe.
	input  rtf_iq_s [NUM_TX-1:0] tx_in,        // Deframer samples.
	output logic                 tx_take,      // Samples taken.
	output rtf_dac_s [NUM_TX-1:0] tx_dac,      // Converter pairs.
	output logic                 tx_dac_valid  // Pair strobe.
);
	localparam int CW = $clog2(CAP_N);

	logic [31:0]      ctrl;
	logic [31:0]      tst;
	logic [PT*16-1:0] pcoef;
	logic [CW-1:0]    cap_a;
	logic [CW-1:0]    cap_p;
	logic             cap_done;
	rtf_cap_e         cap_st;
	logic [31:0]      cap_mem [CAP_N];
	logic             aw_h;
	logic             w_h;
	logic [AW-1:0]    aw_a;
	logic [31:0]      w_d;
	logic [3:0]       w_s;
	logic [3:0]       cnt;
	logic             ph;
	rtf_iq_s          ev_h [NUM_TX];
	rtf_iq_s          long_y [NUM_TX];
	rtf_iq_s          pf_y [NUM_TX];
	rtf_iq_s          dec_y;
	rtf_iq_s          rs_y;
	logic             dec_ph;
	logic             dec_vld;
	logic [1:0]       rs_ph;
	logic             rs_vld;
	logic [15:0]      tacc;

	wire wr_go = aw_h && w_h && !bvalid;
	wire ar_go = arvalid && arready;
	wire w_ctrl = aw_a == AW'(`RTF_A_CTRL);
	wire w_test = aw_a == AW'(`RTF_A_TEST);
	wire w_coef = aw_a == AW'(`RTF_A_COEF);
	wire w_capa = aw_a == AW'(`RTF_A_CAPA);
	wire wr_hit = w_ctrl || w_test || w_coef || w_capa;
	wire r_ctrl = araddr == AW'(`RTF_A_CTRL);
	wire r_test = araddr == AW'(`RTF_A_TEST);
	wire r_caps = araddr == AW'(`RTF_A_CAPS);
	wire r_capa = araddr == AW'(`RTF_A_CAPA);
	wire r_capd = araddr == AW'(`RTF_A_CAPD);
	wire rd_hit = r_ctrl || r_test || r_caps || r_capa || r_capd;
	wire cap_go = wr_go && w_ctrl && w_s[1] && w_d[`RTF_F_CAP];
	wire [4:0] cidx = w_d[`RTF_F_CIDX];
	wire [31:0] caps_w = {8'h00, 16'(cap_p), 6'h00, cap_done, cap_st == RTF_CAP_RUN};
	wire [31:0] rd_w = r_ctrl ? ctrl : r_test ? tst : r_caps ? caps_w :
		r_capa ? 32'(cap_a) : r_capd ? cap_mem[cap_a] : 32'h0000_0000;

	wire ddc_on = !ctrl[`RTF_F_DDC_BYP];
	wire rs_on = !ctrl[`RTF_F_RS_BYP];
	wire rs_34 = ctrl[`RTF_F_RS_34];
	wire test_on = ctrl[`RTF_F_TEST];
	wire pf_on = !ctrl[`RTF_F_PF_BYP];
	wire rtf_txmode_e mode = rtf_txmode_e'(ctrl[`RTF_F_MODE]);
	wire rtf_gain_e gain = rtf_gain_e'(ctrl[`RTF_F_GAIN]);
	wire tri_on = mode == RTF_TX_WIDE || mode == RTF_TX_NAR;
	wire short_on = !tri_on && ctrl[`RTF_F_SHORT];
	wire med_on = !tri_on && ctrl[`RTF_F_MED];
	wire long_on = ctrl[`RTF_F_LONG];
	wire [4:0] psh = gain == RTF_G_P6 ? `RTF_SH_P6 : gain == RTF_G_M6 ? `RTF_SH_M6 : `RTF_SH_0DB;

	// Stage periods in output cycles; the long halfband output runs every cycle.
	wire [3:0] p1 = long_on ? 4'h2 : 4'h1;
	wire [3:0] fm = tri_on ? 4'h3 : med_on ? 4'h2 : 4'h1;
	wire [3:0] p2 = 4'(p1 * fm);
	wire [3:0] p3 = short_on ? 4'(p2 * 4'h2) : p2;
	wire ce1 = rtf_hit(cnt, p1);
	wire ce2 = rtf_hit(cnt, p2);
	wire ce3 = cnt == 4'h0;
	wire [3:0] next_cnt = cnt >= p3 - 4'h1 ? 4'h0 : cnt + 4'h1;
	wire [1:0] rs_last = rs_34 ? 2'h3 : 2'h2;
	wire rtf_iq_s tval = {tacc, -tacc};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_h <= 1'b0;
			w_h <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RTF_OKAY;
			aw_a <= '0;
			w_d <= '0;
			w_s <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_h <= 1'b1;
				aw_a <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_h <= 1'b1;
				w_d <= wdata;
				w_s <= wstrb;
				wready <= 1'b0;
			end
			if (wr_go) begin
				aw_h <= 1'b0;
				w_h <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? `RTF_OKAY : `RTF_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `RTF_CTRL_RST;
			tst <= `RTF_TEST_RST;
			pcoef <= '0;
			cap_a <= '0;
		end else if (wr_go) begin
			// The capture start bit is a strobe and is never stored.
			if (w_ctrl)
				ctrl <= rtf_merge(ctrl, w_d, w_s) & `RTF_CTRL_MASK;
			if (w_test)
				tst <= rtf_merge(tst, w_d, w_s);
			if (w_coef && 32'(cidx) < PT)
				pcoef[cidx*16 +: 16] <= w_d[15:0];
			if (w_capa)
				cap_a <= w_d[CW-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `RTF_OKAY;
		end else begin
			if (ar_go) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rd_w;
				rresp <= rd_hit ? `RTF_OKAY : `RTF_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 4'h0;
			tx_take <= 1'b1;
		end else begin
			cnt <= next_cnt;
			tx_take <= next_cnt == 4'h0;
		end
	end

	for (genvar c = 0; c < NUM_TX; c++) begin : g_tx
		rtf_iq_s sh_y;
		rtf_iq_s md_y;
		rtf_iq_s wd_y;
		rtf_iq_s nr_y;
		rtf_fir #(.NT(5)) u_short (.aclk(aclk), .aresetn(aresetn), .run(ce2), .take(ce3),
			.en(short_on), .coef(`RTF_K_SHORT), .sh(`RTF_SH_0DB), .x(tx_in[c]), .y(sh_y));
		rtf_fir #(.NT(7)) u_med (.aclk(aclk), .aresetn(aresetn), .run(ce1), .take(ce2),
			.en(med_on), .coef(`RTF_K_MED), .sh(`RTF_SH_0DB), .x(sh_y), .y(md_y));
		rtf_fir #(.NT(5)) u_wide (.aclk(aclk), .aresetn(aresetn), .run(ce1), .take(ce3),
			.en(1'b1), .coef(`RTF_K_WIDE), .sh(`RTF_SH_0DB), .x(tx_in[c]), .y(wd_y));
		rtf_fir #(.NT(17)) u_nar (.aclk(aclk), .aresetn(aresetn), .run(ce1), .take(ce3),
			.en(1'b1), .coef(`RTF_K_NAR), .sh(`RTF_SH_0DB), .x(tx_in[c]), .y(nr_y));
		rtf_fir #(.NT(3)) u_long (.aclk(aclk), .aresetn(aresetn), .run(1'b1), .take(ce1),
			.en(long_on), .coef(`RTF_K_LONG), .sh(`RTF_SH_0DB),
			.x(mode == RTF_TX_WIDE ? wd_y : mode == RTF_TX_NAR ? nr_y : md_y),
			.y(long_y[c]));
		rtf_fir #(.NT(PT)) u_pfir (.aclk(aclk), .aresetn(aresetn), .run(1'b1), .take(1'b1),
			.en(pf_on), .coef(pcoef), .sh(psh), .x(long_y[c]), .y(pf_y[c]));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph <= 1'b0;
			tx_dac_valid <= 1'b0;
			tx_dac <= '0;
			for (int c = 0; c < NUM_TX; c++)
				ev_h[c] <= '0;
		end else begin
			ph <= ~ph;
			tx_dac_valid <= ph;
			for (int c = 0; c < NUM_TX; c++)
				if (ph)
					tx_dac[c] <= {ev_h[c], pf_y[c]};
				else
					ev_h[c] <= pf_y[c];
		end
	end

	rtf_fir #(.NT(3)) u_dec (.aclk(aclk), .aresetn(aresetn), .run(rx_in_valid), .take(1'b1),
		.en(ddc_on), .coef(`RTF_K_DEC), .sh(`RTF_SH_0DB), .x(rx_in), .y(dec_y));

	rtf_fir #(.NT(2)) u_rs (.aclk(aclk), .aresetn(aresetn), .run(dec_vld), .take(1'b1),
		.en(rs_on), .coef(rs_34 ? `RTF_K_RS34 : `RTF_K_RS23), .sh(`RTF_SH_0DB),
		.x(dec_y), .y(rs_y));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dec_ph <= 1'b0;
			dec_vld <= 1'b0;
		end else begin
			dec_vld <= rx_in_valid && (!ddc_on || dec_ph);
			if (rx_in_valid)
				dec_ph <= ddc_on && !dec_ph;
		end
	end

	// drop one per cycle of phases
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rs_ph <= 2'h0;
			rs_vld <= 1'b0;
		end else begin
			rs_vld <= dec_vld && (!rs_on || rs_ph != rs_last);
			if (dec_vld)
				rs_ph <= (!rs_on || rs_ph == rs_last) ? 2'h0 : rs_ph + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_out <= '0;
			rx_out_valid <= 1'b0;
			tacc <= '0;
		end else begin
			rx_out_valid <= rs_vld;
			if (rs_vld) begin
				rx_out <= test_on ? tval : rs_y;
				tacc <= tacc + tst[15:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_st <= RTF_CAP_IDLE;
			cap_p <= '0;
			cap_done <= 1'b0;
		end else begin
			case (cap_st)
				RTF_CAP_IDLE: begin
					if (cap_go) begin
						cap_st <= RTF_CAP_RUN;
						cap_p <= '0;
						cap_done <= 1'b0;
					end
				end
				RTF_CAP_RUN: begin
					if (rs_vld) begin
						cap_p <= cap_p + 1'b1;
						if (cap_p == CW'(CAP_N - 1)) begin
							cap_st <= RTF_CAP_IDLE;
							cap_done <= 1'b1;
						end
					end
				end
				default: cap_st <= RTF_CAP_IDLE;
			endcase
		end
	end

	// Memory has no reset so it can map onto block RAM.
	always_ff @(posedge aclk) begin
		if (cap_st == RTF_CAP_RUN && rs_vld)
			cap_mem[cap_p] <= rs_y;
	end

	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_dec_pass: assert property (!ddc_on && rx_in_valid |=> dec_vld && dec_y == $past(rx_in))
		else $error("bypassed decimator changed a sample");
	a_dec_half: assert property (rx_in_valid && ddc_on && !dec_ph |=> !dec_vld)
		else $error("decimator kept an odd sample");
	a_rs_drop: assert property (rs_on && !rs_34 && dec_vld && rs_ph == 2'h2 |=> !rs_vld)
		else $error("two-thirds resampler kept the third sample");
	a_rs_keep: assert property (rs_on && rs_34 && dec_vld && rs_ph != 2'h3 |=> rs_vld)
		else $error("three-quarters resampler lost a sample");
	a_test_sub: assert property (test_on && rs_vld |=> rx_out_valid && rx_out == $past(tval))
		else $error("test signal not delivered");
	a_cap_end: assert property (cap_st == RTF_CAP_RUN && rs_vld && cap_p == CW'(CAP_N - 1)
		|=> cap_st == RTF_CAP_IDLE && cap_done)
		else $error("capture did not stop when full");
	a_pfir_pass: assert property (!pf_on |=> pf_y[0] == $past(long_y[0]))
		else $error("bypassed compensation filter changed a sample");
	a_dac_pair: assert property (tx_dac_valid |=> !tx_dac_valid ##1 tx_dac_valid)
		else $error("converter pair cadence broken");
	a_take_gap: assert property (tx_take && p3 == 4'h8 |=> !tx_take [*7] ##1 tx_take)
		else $error("deframer take spacing wrong");
	a_mode_one: assert property (tri_on |-> !short_on && !med_on && p2 == 4'(p1 * 4'h3))
		else $error("triple and halfband paths both active");

	c_cap_done: cover property (!cap_done ##1 cap_done);
	c_nar_out: cover property (mode == RTF_TX_NAR && long_on && tx_dac_valid);
	c_test_out: cover property (test_on && rx_out_valid);
	c_rs_34: cover property (rs_on && rs_34 && rs_vld);
endmodule

// File: verilog/rtf_map.svh
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH
`define RTF_A_CTRL 8'h00
`define RTF_A_TEST 8'h04
`define RTF_A_COEF 8'h08
`define RTF_A_CAPS 8'h0c
`define RTF_A_CAPA 8'h10
`define RTF_A_CAPD 8'h14
`define RTF_F_DDC_BYP 0
`define RTF_F_RS_34 1
`define RTF_F_RS_BYP 2
`define RTF_F_MODE 5:4
`define RTF_F_SHORT 6
`define RTF_F_MED 7
`define RTF_F_LONG 8
`define RTF_F_GAIN 10:9
`define RTF_F_PF_BYP 11
`define RTF_F_TEST 12
`define RTF_F_CAP 13
`define RTF_F_CIDX 20:16
`define RTF_CTRL_RST 32'h0000_0000
`define RTF_CTRL_MASK 32'h0000_1fff
`define RTF_TEST_RST 32'h0000_0001
`define RTF_OKAY 2'h0
`define RTF_SLVERR 2'h2
`define RTF_SH_0DB 5'h0e
`define RTF_SH_P6 5'h0d
`define RTF_SH_M6 5'h0f
`define RTF_K_DEC {16'h2877, 16'h3fda, 16'h2877}
`define RTF_K_RS23 {16'h273f, 16'h273f}
`define RTF_K_RS34 {16'h2cc3, 16'h2cc3}
`define RTF_K_WIDE {16'h1b06, 16'h33c3, 16'h3df4, 16'h33c3, 16'h1b06}
`define RTF_K_NAR {16'h0141, 16'h00c1, 16'h0000, 16'hf979, 16'hf9ba, 16'h0000, \
	16'h1a1a, 16'h3070, 16'h3fc0, 16'h3070, 16'h1a1a, 16'h0000, 16'hf9ba, \
	16'hf979, 16'h0000, 16'h00c1, 16'h0141}
`define RTF_K_SHORT {16'h0925, 16'h2492, 16'h36db, 16'h2492, 16'h0925}
`define RTF_K_MED {16'hf6ff, 16'h0000, 16'h26e2, 16'h3fd8, 16'h26e2, 16'h0000, 16'hf6ff}
`define RTF_K_LONG {16'h2869, 16'h3f92, 16'h2869}
`endif

// File: verilog/rtf_pkg.sv
`include "rtf_map.svh"
package rtf_pkg;
	typedef struct packed {
		logic signed [15:0] i;
		logic signed [15:0] q;
	} rtf_iq_s;
	typedef struct packed {
		rtf_iq_s even;
		rtf_iq_s odd;
	} rtf_dac_s;
	typedef enum logic [1:0] {RTF_TX_HB, RTF_TX_WIDE, RTF_TX_NAR, RTF_TX_RSV} rtf_txmode_e;
	typedef enum logic [1:0] {RTF_G_0DB, RTF_G_P6, RTF_G_M6, RTF_G_RSV} rtf_gain_e;
	typedef enum logic {RTF_CAP_IDLE, RTF_CAP_RUN} rtf_cap_e;

	// Saturation keeps a hot input from wrapping into the opposite sign.
	function automatic logic signed [15:0] rtf_scale(input logic signed [39:0] a,
		input logic [4:0] sh);
		logic signed [39:0] s;
		s = a >>> sh;
		if (s > 40'sh00_0000_7fff)
			return 16'sh7fff;
		if (s < -40'sh00_0000_8000)
			return 16'sh8000;
		return s[15:0];
	endfunction

	function automatic logic [31:0] rtf_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction

	function automatic logic rtf_hit(input logic [3:0] c, input logic [3:0] p);
		return (c % p) == 4'h0;
	endfunction
endpackage

// File: sim/rtf_deframer_model.sv
`timescale 1ns/1ps
module rtf_deframer_model
	import rtf_pkg::*;
#(
	parameter int NUM_TX = 8 // Transmit chains.
) (
	input  wire logic            aclk,    // Clock.
	input  wire logic            aresetn, // Reset, low.
	input  wire logic            tx_take, // Samples taken.
	output rtf_iq_s [NUM_TX-1:0] tx_in    // Deframer samples.
);
	// The ramp wraps every 128 samples so that +6 dB never saturates.
	logic [6:0]  cnt;
	logic [15:0] base;

	assign base = {8'h00, cnt, 1'b0};

	always_comb begin
		for (int c = 0; c < NUM_TX; c++) begin
			tx_in[c].i = base + 16'(c * 256);
			tx_in[c].q = 16'h0000 - (base + 16'(c * 256));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt <= 7'h00;
		else if (tx_take)
			cnt <= cnt + 7'h01;
	end
endmodule

// File: sim/rtf_chains_tb_top.sv
`timescale 1ns/1ps
`include "rtf_map.svh"
module rtf_chains_tb_top
	import rtf_pkg::*;
();
	logic                aclk;
	logic                aresetn;
	logic [7:0]          awaddr;
	logic                awvalid;
	logic                awready;
	logic [31:0]         wdata;
	logic [3:0]          wstrb;
	logic                wvalid;
	logic                wready;
	logic [1:0]          bresp;
	logic                bvalid;
	logic                bready;
	logic [7:0]          araddr;
	logic                arvalid;
	logic                arready;
	logic [31:0]         rdata;
	logic [1:0]          rresp;
	logic                rvalid;
	logic                rready;
	rtf_iq_s             rx_in;
	logic                rx_in_valid;
	rtf_iq_s             rx_out;
	logic                rx_out_valid;
	rtf_iq_s [7:0]       tx_in;
	logic                tx_take;
	rtf_dac_s [7:0]      tx_dac;
	logic                tx_dac_valid;
	int                  errors;
	int                  checked;
	int                  rx_left;
	int                  rx_cnt;
	logic                rx_dc;
	logic                chk_byp;
	rtf_iq_s             h [3];
	logic [31:0]         rate_ctrl [5] = '{32'h5, 32'h4, 32'h1, 32'h3, 32'h0};
	int                  rate_exp [5] = '{24, 12, 16, 18, 8};
	logic [31:0]         per_ctrl [11] = '{32'h0, 32'h40, 32'h80, 32'h100, 32'hc0, 32'h1c0,
		32'h10, 32'h110, 32'h20, 32'h30, 32'h120};
	int                  per_exp [11] = '{1, 2, 2, 2, 4, 8, 3, 6, 3, 1, 6};
	logic [31:0]         g_ctrl [5] = '{32'h800, 32'h0, 32'h200, 32'h400, 32'h600};
	int                  g_step [5] = '{2, 2, 4, 1, 2};

	rtf_chains rtf_chains_i (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rx_in(rx_in), .rx_in_valid(rx_in_valid), .rx_out(rx_out),
		.rx_out_valid(rx_out_valid), .tx_in(tx_in), .tx_take(tx_take), .tx_dac(tx_dac),
		.tx_dac_valid(tx_dac_valid)
	);

	rtf_deframer_model rtf_deframer_model_i (
		.aclk(aclk), .aresetn(aresetn), .tx_take(tx_take), .tx_in(tx_in)
	);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected resp at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk_resp(bresp, er);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk_word(d, ed);
		chk_resp(r, er);
	endtask

	task automatic get_rx(output rtf_iq_s v);
		do @(posedge aclk); while (rx_out_valid !== 1'b1);
		v = rx_out;
	endtask

	task automatic tx_period(output int n);
		repeat (20) @(posedge aclk);
		do @(posedge aclk); while (tx_take !== 1'b1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (tx_take !== 1'b1);
	endtask

	// Sample source for the receive side and the bypass latency monitor.
	always @(posedge aclk) begin
		if (rx_left > 0) begin
			rx_in_valid <= 1'b1;
			rx_in.i <= rx_dc ? 16'h2000 : rx_in.i + 16'h0001;
			rx_in.q <= rx_dc ? 16'h2000 : rx_in.i + 16'h0101;
			rx_left <= rx_left - 1;
		end else
			rx_in_valid <= 1'b0;
		if (rx_out_valid === 1'b1)
			rx_cnt++;
		if (chk_byp && rx_out_valid === 1'b1)
			chk_word(rx_out, h[2]);
		h[2] = h[1];
		h[1] = h[0];
		h[0] = rx_in;
	end

	initial begin
		#100us;
		errors++;
		results();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] d5;
		logic [1:0]  r;
		rtf_iq_s     v1;
		rtf_iq_s     v2;
		int          n;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
		{rx_in, rx_in_valid, rx_dc, chk_byp} = '0;
		{errors, checked, rx_left, rx_cnt} = '0;
		aresetn = 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`RTF_A_CTRL, 32'h0, `RTF_OKAY);
		rdc(`RTF_A_TEST, 32'h1, `RTF_OKAY);
		wr(`RTF_A_CTRL, 32'hffffffff, 4'h1, `RTF_OKAY);
		rdc(`RTF_A_CTRL, 32'hff, `RTF_OKAY);
		wr(`RTF_A_CTRL, 32'h12345678, 4'h2, `RTF_OKAY);
		rdc(`RTF_A_CTRL, 32'h16ff, `RTF_OKAY);
		wr(8'h18, 32'h1, 4'hf, `RTF_SLVERR);
		wr(`RTF_A_CAPS, 32'h1, 4'hf, `RTF_SLVERR);
		rdc(8'h18, 32'h0, `RTF_SLVERR);
		rdc(`RTF_A_COEF, 32'h0, `RTF_SLVERR);
		wr(`RTF_A_CTRL, 32'h5, 4'hf, `RTF_OKAY);
		chk_byp = 1'b1;
		rx_left = 12;
		repeat (20) @(posedge aclk);
		chk_byp = 1'b0;
		for (int k = 0; k < 5; k++) begin
			wr(`RTF_A_CTRL, rate_ctrl[k], 4'hf, `RTF_OKAY);
			repeat (10) @(posedge aclk);
			rx_cnt = 0;
			rx_left = 24;
			repeat (40) @(posedge aclk);
			chk_word(32'(rx_cnt), 32'(rate_exp[k]));
		end
		wr(`RTF_A_CTRL, 32'h4, 4'hf, `RTF_OKAY);
		rx_dc = 1'b1;
		rx_left = 40;
		repeat (24) @(posedge aclk);
		get_rx(v1);
		chk_word(v1, 32'h4864_4864);
		repeat (30) @(posedge aclk);
		rx_dc = 1'b0;
		wr(`RTF_A_TEST, 32'h3, 4'hf, `RTF_OKAY);
		wr(`RTF_A_CTRL, 32'h1005, 4'hf, `RTF_OKAY);
		rx_left = 20;
		get_rx(v1);
		get_rx(v2);
		chk_word({16'h0, v2.i - v1.i}, 32'h3);
		chk_word({16'h0, v1.q + v1.i}, 32'h0);
		repeat (30) @(posedge aclk);
		wr(`RTF_A_CTRL, 32'h2005, 4'hf, `RTF_OKAY);
		rx_left = 300;
		do rd(`RTF_A_CAPS, d, r); while (d[1] !== 1'b1);
		chk_word({31'h0, d[0]}, 32'h0);
		wr(`RTF_A_CAPA, 32'h5, 4'hf, `RTF_OKAY);
		rd(`RTF_A_CAPD, d5, r);
		wr(`RTF_A_CAPA, 32'h6, 4'hf, `RTF_OKAY);
		rd(`RTF_A_CAPD, d, r);
		chk_resp(r, `RTF_OKAY);
		chk_word({16'h0, d[31:16] - d5[31:16]}, 32'h1);
		chk_word({16'h0, d5[15:0] - d5[31:16]}, 32'h100);
		for (int k = 0; k < 11; k++) begin
			wr(`RTF_A_CTRL, per_ctrl[k], 4'hf, `RTF_OKAY);
			tx_period(n);
			chk_word(32'(n), 32'(per_exp[k]));
		end
		n = 0;
		repeat (10) begin
			@(posedge aclk);
			if (tx_dac_valid === 1'b1)
				n++;
		end
		chk_word(32'(n), 32'h5);
		wr(`RTF_A_COEF, 32'h0017_4000, 4'hf, `RTF_OKAY);
		for (int k = 0; k < 5; k++) begin
			wr(`RTF_A_CTRL, g_ctrl[k], 4'hf, `RTF_OKAY);
			repeat (64) @(posedge aclk);
			do @(posedge aclk);
			while (!(tx_dac_valid === 1'b1 && tx_dac[0].odd.i > tx_dac[0].even.i));
			for (int c = 0; c < 8; c++) begin
				chk_word({16'h0, tx_dac[c].odd.i - tx_dac[c].even.i}, 32'(g_step[k]));
				chk_word({16'h0, tx_dac[c].even.i - tx_dac[0].even.i},
					32'(c * 128 * g_step[k]));
				chk_word({16'h0, tx_dac[c].even.q + tx_dac[c].even.i}, 32'h0);
			end
		end
		results();
	end
endmodule
